// >>> ait_pkg.sv
// constants, field layout and state type of the analog input self-test block
// assumes a 200 MHz clock; nothing else is shared outside this package
package ait_pkg;

   // control word layout, controller bit n sits at index n-1
   localparam int          CW_W           = 16;
   localparam int          CW_TEST_EN_POS = 13;
   localparam int          CW_SEL_LO_POS  = 14;
   localparam int          CW_SEL_HI_POS  = 15;
   localparam logic [2:0]  TB_NONE        = 3'h0;
   localparam logic [2:0]  TB_SET_A       = 3'h3;
   localparam logic [2:0]  TB_SET_B       = 3'h5;
   localparam logic [15:0] CW_RST         = 16'h0000;

   // register map as seen by the controller
   localparam int         OUT_REGS    = 3;
   localparam int         IN_REGS     = 3;
   localparam logic [1:0] IREG_STATUS = 2'h0;
   localparam logic [1:0] IREG_FAULT  = 2'h1;
   localparam logic [1:0] IREG_TEST   = 2'h2;

   // status word fields
   localparam int ST_COMM_POS    = 0;
   localparam int ST_PU_DONE_POS = 1;
   localparam int ST_BUSY_POS    = 2;
   localparam int ST_SET_LO_POS  = 3;
   localparam int ST_TFAIL_POS   = 5;
   localparam int ST_FAULT_POS   = 6;
   localparam int ST_RESTART_POS = 7;
   localparam int ST_TMODE_POS   = 8;

   // fault pins, one per listed fault
   localparam int NUM_FLT     = 7;
   localparam int FLT_WDOG    = 0;
   localparam int FLT_WDOG_PU = 1;
   localparam int FLT_RAM_PU  = 2;
   localparam int FLT_BUS_PU  = 3;
   localparam int FLT_ROM     = 4;
   localparam int FLT_CPU_PU  = 5;
   localparam int FLT_GENERAL = 6;

   // test elements: set A 0..5, set B 6..11
   localparam int         NUM_ELEM    = 12;
   localparam logic [3:0] EL_CPU      = 4'h0;
   localparam logic [3:0] EL_DPRAM    = 4'h1;
   localparam logic [3:0] EL_PROM     = 4'h2;
   localparam logic [3:0] EL_WDOG     = 4'h3;
   localparam logic [3:0] EL_LEDS     = 4'h4;
   localparam logic [3:0] EL_PSU_A    = 4'h5;
   localparam logic [3:0] EL_EEPROM   = 4'h6;
   localparam logic [3:0] EL_BIU      = 4'h7;
   localparam logic [3:0] EL_ANALOG   = 4'h8;
   localparam logic [3:0] EL_ISO      = 4'h9;
   localparam logic [3:0] EL_PSU_B    = 4'hA;
   localparam logic [3:0] EL_FW       = 4'hB;

   // timing
   localparam int CLK_PERIOD_PS    = 5000;
   localparam int BLINK_HALF_MS    = 250;
   localparam int BLINK_HALF_CYC   =
      BLINK_HALF_MS * (1000000000 / CLK_PERIOD_PS);
   localparam int ELEM_TIMEOUT_US  = 100;
   localparam int ELEM_TIMEOUT_CYC =
      ELEM_TIMEOUT_US * (1000000 / CLK_PERIOD_PS);

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_START = 3'b001,
      ST_WAIT  = 3'b010,
      ST_NEXT  = 3'b011,
      ST_DONE  = 3'b100
   } ait_state_e;

endpackage : ait_pkg

// >>> ait_blink.sv
// free-running blink phase generator
// assumes the single module clock; phase toggles every HALF_CYC cycles
`timescale 1ns/10ps
`default_nettype none
module ait_blink #(
   parameter int HALF_CYC = 50000000
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rstn_i,
   // phase out
   output logic      blink_o
);

   logic [31:0] cnt_ff;
   logic        phase_ff;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_ff <= 32'h0000_0000;
      end else if (cnt_ff == 32'(HALF_CYC - 1)) begin
         cnt_ff <= 32'h0000_0000;
      end else begin
         cnt_ff <= cnt_ff + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         phase_ff <= 1'b0;
      end else if (cnt_ff == 32'(HALF_CYC - 1)) begin
         phase_ff <= ~phase_ff;
      end
   end

   assign blink_o = phase_ff;

endmodule : ait_blink
`default_nettype wire

// >>> ait_top.sv
// self-test sequencer and indicator logic of the analog input module
// assumes controller register port and test engines run on clk_i;
// fault and link-state pins are asynchronous and synchronised here
//
// How it works
// - tests run once after reset and again on demand via control word
// - control bit 14 set enters self-test; clearing it ends self-test
// - bits 16 and 15 pick the test set; all three zero means no test
// - set A: cpu, dual-port ram, program memory, watchdog, leds, supply
// - set B: eeprom, bus unit, analog, isolation link, supply, firmware
// - green blinks while any test bit set; restart flagged after clearing
// - amber blinks on watchdog, ram, bus, rom, cpu or general faults
// - amber blinks when any built-in test element fails
// - green blinks after power-up, steady once controller link is up and no test bit is set
// - exactly three readable and three writable registers are presented
`timescale 1ns/10ps
`default_nettype none
module ait_top #(
   parameter int BLINK_HALF_CYC   = ait_pkg::BLINK_HALF_CYC,
   parameter int ELEM_TIMEOUT_CYC = ait_pkg::ELEM_TIMEOUT_CYC
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   // controller register port
   input  wire logic        wr_en_i,
   input  wire logic [1:0]  wr_idx_i,
   input  wire logic [15:0] wr_data_i,
   input  wire logic        rd_en_i,
   input  wire logic [1:0]  rd_idx_i,
   output logic      [15:0] rd_data_o,
   // asynchronous status pins
   input  wire logic [6:0]  fault_i,
   input  wire logic        comm_up_i,
   // test engine handshake
   output logic             elem_start_o,
   output logic      [3:0]  elem_sel_o,
   input  wire logic        elem_done_i,
   input  wire logic        elem_pass_i,
   // indicators and flags
   output logic             green_o,
   output logic             amber_o,
   output logic             test_busy_o,
   output logic             restart_req_o
);

   // synchronisers
   logic [7:0]  sync1_ff;
   logic [7:0]  sync2_ff;
   logic [6:0]  flt_s;
   logic        comm_s;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync1_ff <= 8'h00;
         sync2_ff <= 8'h00;
      end else begin
         sync1_ff <= {comm_up_i, fault_i};
         sync2_ff <= sync1_ff;
      end
   end

   assign flt_s  = sync2_ff[6:0];
   assign comm_s = sync2_ff[7];

   // writable registers
   logic [15:0] oreg_ff [ait_pkg::OUT_REGS];
   logic [2:0]  tbits;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < ait_pkg::OUT_REGS; i++) begin
            oreg_ff[i] <= ait_pkg::CW_RST;
         end
      end else if (wr_en_i && (int'(wr_idx_i) < ait_pkg::OUT_REGS)) begin
         oreg_ff[wr_idx_i] <= wr_data_i;
      end
   end

   assign tbits = {oreg_ff[0][ait_pkg::CW_SEL_HI_POS],
                   oreg_ff[0][ait_pkg::CW_SEL_LO_POS],
                   oreg_ff[0][ait_pkg::CW_TEST_EN_POS]};

   logic test_en;
   logic sel_a;
   logic sel_b;
   assign test_en = tbits[0];
   assign sel_a   = (tbits == ait_pkg::TB_SET_A);
   assign sel_b   = (tbits == ait_pkg::TB_SET_B);

   // sequencer
   ait_pkg::ait_state_e state_ff;
   logic [3:0]  elem_ff;
   logic [3:0]  first_ff;
   logic [3:0]  last_ff;
   logic        pu_run_ff;
   logic        pu_done_ff;
   logic [1:0]  set_ff;
   logic [31:0] tmr_ff;
   logic        tmo;
   logic        abort;

   assign tmo   = (tmr_ff == 32'(ELEM_TIMEOUT_CYC - 1));
   // online run stops as soon as enable drops or selection changes
   assign abort = !pu_run_ff && (!test_en ||
                  !((set_ff == 2'h1 && sel_a) || (set_ff == 2'h2 && sel_b)));

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_ff  <= ait_pkg::ST_IDLE;
         elem_ff   <= ait_pkg::EL_CPU;
         first_ff  <= ait_pkg::EL_CPU;
         last_ff   <= ait_pkg::EL_FW;
         pu_run_ff <= 1'b0;
         set_ff    <= 2'h0;
      end else begin
         case (state_ff)
            ait_pkg::ST_IDLE: begin
               if (!pu_done_ff) begin
                  first_ff  <= ait_pkg::EL_CPU;
                  elem_ff   <= ait_pkg::EL_CPU;
                  last_ff   <= ait_pkg::EL_FW;
                  pu_run_ff <= 1'b1;
                  set_ff    <= 2'h3;
                  state_ff  <= ait_pkg::ST_START;
               end else if (sel_a) begin
                  first_ff  <= ait_pkg::EL_CPU;
                  elem_ff   <= ait_pkg::EL_CPU;
                  last_ff   <= ait_pkg::EL_PSU_A;
                  pu_run_ff <= 1'b0;
                  set_ff    <= 2'h1;
                  state_ff  <= ait_pkg::ST_START;
               end else if (sel_b) begin
                  first_ff  <= ait_pkg::EL_EEPROM;
                  elem_ff   <= ait_pkg::EL_EEPROM;
                  last_ff   <= ait_pkg::EL_FW;
                  pu_run_ff <= 1'b0;
                  set_ff    <= 2'h2;
                  state_ff  <= ait_pkg::ST_START;
               end
            end
            ait_pkg::ST_START: begin
               state_ff <= abort ? ait_pkg::ST_IDLE : ait_pkg::ST_WAIT;
            end
            ait_pkg::ST_WAIT: begin
               if (elem_done_i || tmo) begin
                  if (elem_ff == last_ff) begin
                     state_ff <= ait_pkg::ST_DONE;
                  end else begin
                     state_ff <= ait_pkg::ST_NEXT;
                  end
               end else if (abort) begin
                  state_ff <= ait_pkg::ST_IDLE;
               end
            end
            ait_pkg::ST_NEXT: begin
               elem_ff  <= elem_ff + 4'h1;
               state_ff <= abort ? ait_pkg::ST_IDLE : ait_pkg::ST_START;
            end
            ait_pkg::ST_DONE: begin
               // online test repeats while its selection stays put
               if (pu_run_ff || abort) begin
                  pu_run_ff <= 1'b0;
                  set_ff    <= 2'h0;
                  state_ff  <= ait_pkg::ST_IDLE;
               end else begin
                  elem_ff  <= first_ff;
                  state_ff <= ait_pkg::ST_START;
               end
            end
            default: begin
               state_ff <= ait_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // element timer
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tmr_ff <= 32'h0000_0000;
      end else if (state_ff == ait_pkg::ST_WAIT) begin
         tmr_ff <= tmr_ff + 32'h0000_0001;
      end else begin
         tmr_ff <= 32'h0000_0000;
      end
   end

   // power-up run completion
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pu_done_ff <= 1'b0;
      end else if (state_ff == ait_pkg::ST_DONE && pu_run_ff) begin
         pu_done_ff <= 1'b1;
      end
   end

   // sticky failures, cleared only by reset
   logic [11:0] efail_ff;
   logic [6:0]  flt_ff;
   logic        tfail;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         efail_ff <= 12'h000;
      end else if (state_ff == ait_pkg::ST_WAIT &&
                   ((elem_done_i && !elem_pass_i) ||
                    (!elem_done_i && tmo))) begin
         efail_ff[elem_ff] <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flt_ff <= 7'h00;
      end else begin
         flt_ff <= flt_ff | flt_s;
      end
   end

   assign tfail = |efail_ff;

   // restart request after leaving test mode
   logic tmode_seen_ff;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tmode_seen_ff <= 1'b0;
      end else if (tbits != ait_pkg::TB_NONE) begin
         tmode_seen_ff <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         restart_req_o <= 1'b0;
      end else if (tmode_seen_ff && tbits == ait_pkg::TB_NONE) begin
         restart_req_o <= 1'b1;
      end
   end

   // indicators
   logic blink;

   ait_blink #(
      .HALF_CYC (BLINK_HALF_CYC)
   ) u_blink (
      .clk_i   (clk_i),
      .rstn_i  (rstn_i),
      .blink_o (blink)
   );

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         green_o <= 1'b0;
      end else if (tbits != ait_pkg::TB_NONE) begin
         green_o <= blink;
      end else if (comm_s) begin
         green_o <= 1'b1;
      end else begin
         green_o <= blink;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         amber_o <= 1'b0;
      end else if ((|flt_ff) || tfail) begin
         amber_o <= blink;
      end else begin
         amber_o <= 1'b0;
      end
   end

   // test engine outputs
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         elem_start_o <= 1'b0;
         elem_sel_o   <= ait_pkg::EL_CPU;
         test_busy_o  <= 1'b0;
      end else begin
         elem_start_o <= (state_ff == ait_pkg::ST_START) && !abort;
         elem_sel_o   <= elem_ff;
         test_busy_o  <= (state_ff != ait_pkg::ST_IDLE);
      end
   end

   // readable registers
   logic [15:0] status_w;

   always_comb begin
      status_w = 16'h0000;
      status_w[ait_pkg::ST_COMM_POS]     = comm_s;
      status_w[ait_pkg::ST_PU_DONE_POS]  = pu_done_ff;
      status_w[ait_pkg::ST_BUSY_POS]     = test_busy_o;
      status_w[ait_pkg::ST_SET_LO_POS]   = set_ff[0];
      status_w[ait_pkg::ST_SET_LO_POS+1] = set_ff[1];
      status_w[ait_pkg::ST_TFAIL_POS]    = tfail;
      status_w[ait_pkg::ST_FAULT_POS]    = |flt_ff;
      status_w[ait_pkg::ST_RESTART_POS]  = restart_req_o;
      status_w[ait_pkg::ST_TMODE_POS]    = tbits != ait_pkg::TB_NONE;
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rd_data_o <= 16'h0000;
      end else if (rd_en_i) begin
         case (rd_idx_i)
            ait_pkg::IREG_STATUS: rd_data_o <= status_w;
            ait_pkg::IREG_FAULT:  rd_data_o <= {9'h000, flt_ff};
            ait_pkg::IREG_TEST:   rd_data_o <= {elem_ff, efail_ff};
            default:              rd_data_o <= 16'h0000;
         endcase
      end
   end

endmodule : ait_top
`default_nettype wire

// >>> ait_top_monitor.sv
// port-level assertions for the analog input self-test block
// bound into every ait_top instance; single clock domain
`timescale 1ns/10ps
`default_nettype none
module ait_mon #(
   parameter int BLINK_HALF_CYC   = 8,
   parameter int ELEM_TIMEOUT_CYC = 16
) (
   // watched ports of ait_top
   input wire logic        clk_i,
   input wire logic        rstn_i,
   input wire logic        wr_en_i,
   input wire logic [1:0]  wr_idx_i,
   input wire logic [15:0] wr_data_i,
   input wire logic        rd_en_i,
   input wire logic [1:0]  rd_idx_i,
   input wire logic [15:0] rd_data_o,
   input wire logic [6:0]  fault_i,
   input wire logic        comm_up_i,
   input wire logic        elem_start_o,
   input wire logic [3:0]  elem_sel_o,
   input wire logic        elem_done_i,
   input wire logic        elem_pass_i,
   input wire logic        green_o,
   input wire logic        amber_o,
   input wire logic        test_busy_o,
   input wire logic        restart_req_o
);
   localparam int LIM = BLINK_HALF_CYC + 6;
   logic [2:0] tb_ff;
   logic       g_ff;
   logic       bad_ff;
   int         gst_ff;
   int         wt_ff;
   logic [3:0] gon_ff;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // shadow of test bits, fault history, green stability counters
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tb_ff  <= 3'h0;
         g_ff   <= 1'b0;
         bad_ff <= 1'b0;
         gst_ff <= 0;
         wt_ff  <= 0;
         gon_ff <= 4'h0;
      end else begin
         if (wr_en_i && wr_idx_i == 2'h0)
            tb_ff <= wr_data_i[15:13];
         g_ff   <= green_o;
         // unanswered element counts as a failure once it reaches timeout
         wt_ff  <= elem_start_o ? 1 : (elem_done_i || wt_ff == 0) ?
                   0 : wt_ff + 1;
         bad_ff <= bad_ff | (|fault_i) | (elem_done_i & ~elem_pass_i) |
                   (wt_ff >= ELEM_TIMEOUT_CYC - 1);
         gst_ff <= (green_o != g_ff || (tb_ff == 3'h0 && comm_up_i)) ?
                   0 : gst_ff + 1;
         gon_ff <= !(comm_up_i && tb_ff == 3'h0) ? 4'h0 :
                   (gon_ff == 4'h8) ? gon_ff : gon_ff + 4'h1;
      end
   end
   a_powerup_start: assert property (
      $rose(rstn_i) |-> ##2 elem_start_o && elem_sel_o == 4'h0)
      else $error("power-up run did not start");
   a_start_gap: assert property (
      elem_done_i |=> !elem_start_o [*2])
      else $error("next element started too early");
   a_sel_range: assert property (
      elem_start_o |-> elem_sel_o <= 4'hB)
      else $error("element code out of range");
   a_idle_quiet: assert property (
      $past(rstn_i, 2) && !test_busy_o && tb_ff != 3'h3 && tb_ff != 3'h5
      |=> !elem_start_o)
      else $error("element started without a test set");
   a_restart_set: assert property (
      tb_ff != 3'h0 ##1 tb_ff == 3'h0 |-> ##[1:3] restart_req_o)
      else $error("restart flag not raised");
   a_green_blinks: assert property (
      gst_ff <= LIM)
      else $error("green stopped blinking");
   a_green_steady: assert property (
      gon_ff == 4'h8 |-> green_o)
      else $error("green not steady with link up");
   a_amber_fault: assert property (
      |fault_i |-> ##[1:LIM] amber_o)
      else $error("amber silent on fault");
   a_amber_quiet: assert property (
      !bad_ff |-> !amber_o)
      else $error("amber on without cause");
   a_rd_unmapped: assert property (
      rd_en_i && rd_idx_i == 2'h3 |=> rd_data_o == 16'h0000)
      else $error("unmapped read not zero");
endmodule : ait_mon

bind ait_top ait_mon #(
   .BLINK_HALF_CYC(BLINK_HALF_CYC),
   .ELEM_TIMEOUT_CYC(ELEM_TIMEOUT_CYC)
) mon_u (
   .clk_i(clk_i), .rstn_i(rstn_i), .wr_en_i(wr_en_i),
   .wr_idx_i(wr_idx_i), .wr_data_i(wr_data_i), .rd_en_i(rd_en_i),
   .rd_idx_i(rd_idx_i), .rd_data_o(rd_data_o), .fault_i(fault_i),
   .comm_up_i(comm_up_i), .elem_start_o(elem_start_o),
   .elem_sel_o(elem_sel_o), .elem_done_i(elem_done_i),
   .elem_pass_i(elem_pass_i), .green_o(green_o), .amber_o(amber_o),
   .test_busy_o(test_busy_o), .restart_req_o(restart_req_o)
);
`default_nettype wire

// >>> ait_eng_model.sv
// behavioural test-engine partner of the self-test sequencer
// answers each start pulse after a bench-chosen delay unless muted
`timescale 1ns/10ps
`default_nettype none
module ait_eng_model (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   // from the sequencer
   input  wire logic        start_i,
   input  wire logic [3:0]  sel_i,
   // bench controls
   input  wire logic [11:0] fail_i,
   input  wire logic [2:0]  dly_i,
   input  wire logic        mute_i,
   // answer
   output logic             done_o,
   output logic             pass_o
);
   logic [3:0] cnt_ff;
   logic [3:0] sel_ff;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_ff <= 4'h0;
         sel_ff <= 4'h0;
         done_o <= 1'b0;
         pass_o <= 1'b0;
      end else begin
         done_o <= (cnt_ff == 4'h1);
         // pass toggles whenever done does not qualify it
         pass_o <= (cnt_ff == 4'h1) ? ~fail_i[sel_ff] : ~pass_o;
         // muted engine never answers, forcing the sequencer timeout
         if (start_i && !mute_i) begin
            cnt_ff <= {1'b0, dly_i} + 4'h1;
            sel_ff <= sel_i;
         end else if (cnt_ff != 4'h0)
            cnt_ff <= cnt_ff - 4'h1;
      end
   end
endmodule : ait_eng_model
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the analog input self-test block
// drives controller port, pins and the test-engine partner
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam int HALF = 8;
   localparam int TMO  = 16;
   logic        clk_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic        wr_en_i = 1'b0;
   logic [1:0]  wr_idx_i = 2'h0;
   logic [15:0] wr_data_i = 16'h0000;
   logic        rd_en_i = 1'b0;
   logic [1:0]  rd_idx_i = 2'h0;
   logic [6:0]  fault_i = 7'h00;
   logic        comm_up_i = 1'b0;
   logic [11:0] fail = 12'h000;
   logic [2:0]  dly = 3'h0;
   logic        mute = 1'b0;
   logic [15:0] rd_data_o;
   logic [15:0] d;
   logic [3:0]  elem_sel_o;
   logic        elem_start_o, elem_done_i, elem_pass_i;
   logic        green_o, amber_o, test_busy_o, restart_req_o;
   logic [2:0]  codes [7] = '{3'h3, 3'h5, 3'h1, 3'h2, 3'h4, 3'h6, 3'h7};
   logic [3:0]  sq [$];
   int          num_errors = 0, checks = 0, cyc = 0, ldone = -100;
   int          seed = 32'hc9d2, gch, amb, k;
   ait_top #(.BLINK_HALF_CYC(HALF), .ELEM_TIMEOUT_CYC(TMO)) dut_u (
      .clk_i(clk_i), .rstn_i(rstn_i), .wr_en_i(wr_en_i),
      .wr_idx_i(wr_idx_i), .wr_data_i(wr_data_i), .rd_en_i(rd_en_i),
      .rd_idx_i(rd_idx_i), .rd_data_o(rd_data_o), .fault_i(fault_i),
      .comm_up_i(comm_up_i), .elem_start_o(elem_start_o),
      .elem_sel_o(elem_sel_o), .elem_done_i(elem_done_i),
      .elem_pass_i(elem_pass_i), .green_o(green_o), .amber_o(amber_o),
      .test_busy_o(test_busy_o), .restart_req_o(restart_req_o));
   ait_eng_model eng_u (
      .clk_i(clk_i), .rstn_i(rstn_i), .start_i(elem_start_o),
      .sel_i(elem_sel_o), .fail_i(fail), .dly_i(dly), .mute_i(mute),
      .done_o(elem_done_i), .pass_o(elem_pass_i));
   always #2.5 clk_i = ~clk_i;
   task automatic print_verdict();
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                      input string msg);
      checks = checks + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk
   function automatic logic [3:0] exp_el(input logic [2:0] t, input int n);
      if (t == ait_pkg::TB_SET_A)
         return 4'(n % 6);
      if (t == ait_pkg::TB_SET_B)
         return ait_pkg::EL_EEPROM + 4'(n % 6);
      return 4'(n % 12);
   endfunction : exp_el
   task automatic cyc_n(input int n);
      repeat (n) @(posedge clk_i);
   endtask : cyc_n
   task automatic do_reset();
      @(posedge clk_i);
      rstn_i  <= 1'b0;
      fault_i <= 7'h00;
      sq.delete();
      cyc_n(6);
      rstn_i <= 1'b1;
   endtask : do_reset
   task automatic wr(input logic [1:0] idx, input logic [15:0] v);
      @(posedge clk_i);
      wr_en_i   <= 1'b1;
      wr_idx_i  <= idx;
      wr_data_i <= v;
      @(posedge clk_i);
      wr_en_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [1:0] idx, output logic [15:0] v);
      @(posedge clk_i);
      rd_en_i  <= 1'b1;
      rd_idx_i <= idx;
      @(posedge clk_i);
      rd_en_i <= 1'b0;
      #1;
      v = rd_data_o;
   endtask : rd
   task automatic watch(input int n, output int gc, output int am);
      logic g;
      gc = 0;
      am = 0;
      g = green_o;
      repeat (n) begin
         @(posedge clk_i);
         #1;
         gc = gc + int'(green_o !== g);
         g = green_o;
         am = am + int'(amber_o === 1'b1);
      end
   endtask : watch
   task automatic wait_idle();
      int i;
      for (i = 0; i < 400 && test_busy_o !== 1'b0; i++)
         @(posedge clk_i);
      #1;
      chk(16'(test_busy_o), 16'h0000, "sequencer idle");
   endtask : wait_idle
   task automatic chk_seq(input logic [2:0] t, input int n);
      int i;
      chk(16'(sq.size() >= n), 16'h0001, "run length");
      for (i = 0; i < n && i < sq.size(); i++)
         chk(16'(sq[i]), 16'(exp_el(t, i)), "element order");
   endtask : chk_seq
   // start log, spacing check, random partner delay, hang guard
   always @(posedge clk_i) begin
      cyc = cyc + 1;
      if (!rstn_i)
         ldone = -100;
      if (elem_done_i)
         ldone = cyc;
      if (elem_start_o) begin
         sq.push_back(elem_sel_o);
         dly <= 3'($random(seed));
         if (cyc - ldone < 10 && elem_sel_o != 4'h0 && elem_sel_o != 4'h6)
            chk(16'(cyc - ldone), 16'h0003, "start spacing");
      end
      if (cyc == 5000) begin
         num_errors = num_errors + 1;
         print_verdict();
      end
   end
   initial begin
      do_reset();
      cyc_n(4);
      wait_idle();
      chk_seq(3'h0, 12);
      rd(2'h0, d);
      chk(d & 16'h0002, 16'h0002, "power-up done flag");
      @(posedge clk_i);
      comm_up_i <= 1'b1;
      cyc_n(6);
      watch(20, gch, amb);
      chk(16'(gch), 16'h0000, "green steady");
      chk(16'(amb), 16'h0000, "amber quiet");
      $display("test power-up and link done");
      foreach (codes[i]) begin
         sq.delete();
         wr(2'h0, {codes[i], 13'($random(seed))});
         watch(4 * HALF, gch, amb);
         chk(16'(gch > 1), 16'h0001, "green blinks");
         rd(2'h0, d);
         chk(d & 16'h0100, 16'h0100, "test mode flag");
         cyc_n(120);
         if (i < 2)
            chk_seq(codes[i], 8);
         else
            chk(16'(sq.size()), 16'h0000, "no test run");
         wr(2'h0, {3'h0, 13'($random(seed))});
         cyc_n(20);
         chk(16'(restart_req_o), 16'h0001, "restart flag");
         wait_idle();
      end
      wr(2'h3, (16'($random(seed)) & 16'h1FFF) | 16'h6000);
      rd(2'h3, d);
      chk(d, 16'h0000, "unmapped read");
      chk(16'(test_busy_o), 16'h0000, "unmapped write ignored");
      $display("test control word done");
      for (k = 0; k < 7; k++) begin
         do_reset();
         fault_i <= 7'(1 << k);
         watch(2 * HALF + 8, gch, amb);
         chk(16'(amb > 0), 16'h0001, "amber on fault");
         rd(2'h1, d);
         chk(d & 16'h007F, 16'(1 << k), "fault word");
      end
      $display("test faults done");
      k = $unsigned($random(seed)) % 12;
      fail <= 12'h001 << k;
      do_reset();
      cyc_n(4);
      wait_idle();
      watch(2 * HALF + 4, gch, amb);
      chk(16'(amb > 0), 16'h0001, "amber on failed test");
      rd(2'h2, d);
      chk(d & 16'h0FFF, 16'(fail), "failed element bits");
      $display("test failed element done");
      mute <= 1'b1;
      do_reset();
      cyc_n(4);
      wait_idle();
      rd(2'h2, d);
      chk(d & 16'h0FFF, 16'h0FFF, "timed-out elements");
      $display("test element timeout done");
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
